// ---- tsc_touch_ctrl.sv ----
// Touch controller top: registers, recalibration, blocking, events
`timescale 1ns/1ps
`default_nettype none
module tsc_touch_ctrl #(
  parameter int TICK_CYC_P = tsc_pkg::TICK_CYC, // Cycles per 35 ms step
  parameter int SAMPLE_CYC_P = tsc_pkg::SAMPLE_BASE_CYC // Cycles per 320 us
) (
  input wire logic i_sys_clk, // System clock, 10 MHz
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_reg_wr, // Register write strobe
  input wire logic i_reg_rd, // Register read strobe
  input wire logic [7:0] i_reg_addr, // Register offset
  input wire logic [7:0] i_reg_wdata, // Write data
  output logic [7:0] o_reg_rdata, // Read data, next cycle
  input wire logic i_active, // Device in active state
  input wire logic [5:0] i_input_enable, // Inputs in the scan
  input wire logic i_release_irq_suppress, // No release events on repeat-enabled inputs
  input wire logic [3:0] i_repeat_interval_select, // Repeat interval code
  input wire logic [15:0] i_afe_count, // Front end sample result
  output var tsc_pkg::tsc_afe_req_t o_afe_req, // Front end request
  output var tsc_pkg::tsc_meas_t o_meas, // Averaged result
  output logic o_low_power, // Rest of cycle period
  input wire logic [5:0] i_touch_raw, // Threshold crossings
  input wire logic [5:0] i_cal_done, // Front end calibration done
  input wire logic [9:0] i_cal_value, // Value for done input
  output logic [5:0] o_cal_start, // Calibration start pulses
  output logic [59:0] o_calibration_value, // Six ten-bit values
  output logic [5:0] o_base_valid, // Base count usable
  output logic [5:0] o_touch_status, // Accepted touches
  output logic o_simultaneous_touch_flag, // Too many touches
  output logic o_irq_req // Interrupt event pulse
);
  import tsc_pkg::*;

  localparam int TW = $clog2(TICK_CYC_P);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] samp_cfg_r;
  logic [5:0] cal_req_r;
  logic [5:0] int_en_r;
  logic [5:0] rpt_en_r;
  logic [7:0] multi_r;
  logic [TW-1:0] tick_cnt_r;
  logic tick;
  logic [5:0] cal_busy_r;
  logic [4:0] cal_tmr_r [NUM_IN];
  logic [CAL_W-1:0] cal_val_r [NUM_IN];
  logic [5:0] cal_ok;
  logic [5:0] cal_tout;
  logic [5:0] cal_end;
  logic [5:0] raw_eff;
  logic [5:0] acc_nxt;
  logic [5:0] acc_r;
  logic simultaneous_touch_flag_nxt;
  logic simultaneous_touch_flag_r;
  logic [2:0] lim;
  logic blk_en;
  logic [5:0] key_ev;
  logic irq_r;
  logic [7:0] rdata_r;
  tsc_cfg_t cfg;

  // Count of set bits in an input mask
  function automatic logic [2:0] ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < NUM_IN; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

  // ----------------------------------------
  // Register writes and reads
  // ----------------------------------------
  // Plain configuration registers
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      samp_cfg_r <= RST_SAMPLING;
      int_en_r <= RST_INT_EN[5:0];
      rpt_en_r <= RST_RPT_EN[5:0];
      multi_r <= RST_MULTI;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_SAMPLING: samp_cfg_r <= i_reg_wdata & SAMPLING_MASK;
        ADDR_INT_EN: int_en_r <= i_reg_wdata[5:0];
        ADDR_RPT_EN: rpt_en_r <= i_reg_wdata[5:0];
        ADDR_MULTI: multi_r <= i_reg_wdata & MULTI_MASK;
        default: ;
      endcase
    end
  end

  // Request bits: writes only set, the routine clears; set wins a tie
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cal_req_r <= RST_CAL_REQ[5:0];
    end else begin
      cal_req_r <= (cal_req_r & ~cal_end)
        | ((i_reg_wr && i_reg_addr == ADDR_CAL_REQ) ? i_reg_wdata[5:0] : 6'h00);
    end
  end

  // Registered read port; unmapped offsets and reserved bits read zero
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_r <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_SAMPLING: rdata_r <= samp_cfg_r;
        ADDR_CAL_REQ: rdata_r <= {2'h0, cal_req_r};
        ADDR_INT_EN: rdata_r <= {2'h0, int_en_r};
        ADDR_RPT_EN: rdata_r <= {2'h0, rpt_en_r};
        ADDR_MULTI: rdata_r <= multi_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign o_reg_rdata = rdata_r;

  // ----------------------------------------
  // 35 ms step divider
  // ----------------------------------------
  // One enable pulse serves the repeat, period and calibration timers
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  assign tick = (tick_cnt_r == TW'(TICK_CYC_P - 1));

  // ----------------------------------------
  // Sampling sequencer
  // ----------------------------------------
  assign cfg.sample_count_select = samp_cfg_r[AVG_LSB +: 3];
  assign cfg.single_sample_duration = samp_cfg_r[SAMP_LSB +: 2];
  assign cfg.cycle_period_select = samp_cfg_r[CYCLE_LSB +: 2];

  tsc_scan_seq #(
    .SAMPLE_CYC(SAMPLE_CYC_P)
  ) u_seq (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_tick(tick),
    .i_active(i_active),
    .i_input_enable(i_input_enable),
    .i_cfg(cfg),
    .i_afe_count(i_afe_count),
    .o_afe(o_afe_req),
    .o_meas(o_meas),
    .o_low_power(o_low_power)
  );

  // ----------------------------------------
  // Forced recalibration
  // ----------------------------------------
  // End conditions; a press outranks a done in the same cycle
  always_comb begin
    cal_ok = cal_busy_r & i_cal_done & ~i_touch_raw;
    for (int i = 0; i < NUM_IN; i++) begin
      cal_tout[i] = cal_busy_r[i] && !i_cal_done[i] && !i_touch_raw[i] && tick
        && (cal_tmr_r[i] == 5'(CAL_TICKS - 1));
    end
    cal_end = cal_ok | cal_tout;
  end

  // Per-input routine; a press restarts the attempt and its timer
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cal_busy_r <= 6'h00;
      o_cal_start <= 6'h00;
      for (int i = 0; i < NUM_IN; i++) begin
        cal_tmr_r[i] <= 5'h00;
      end
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        o_cal_start[i] <= 1'b0;
        if (!cal_busy_r[i]) begin
          if (cal_req_r[i]) begin
            cal_busy_r[i] <= 1'b1;
            cal_tmr_r[i] <= 5'h00;
            o_cal_start[i] <= 1'b1;
          end
        end else if (i_touch_raw[i]) begin
          cal_tmr_r[i] <= 5'h00;
          o_cal_start[i] <= 1'b1;
        end else if (cal_end[i]) begin
          cal_busy_r[i] <= 1'b0;
        end else if (tick) begin
          cal_tmr_r[i] <= cal_tmr_r[i] + 5'h01;
        end
      end
    end
  end

  // Values kept per input; a timed-out attempt leaves the old value
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < NUM_IN; i++) begin
        cal_val_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (cal_ok[i]) begin
          cal_val_r[i] <= i_cal_value;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      o_calibration_value[i*CAL_W +: CAL_W] = cal_val_r[i];
    end
  end

  assign o_base_valid = ~cal_busy_r;

  // ----------------------------------------
  // Simultaneous touch blocking
  // ----------------------------------------
  assign raw_eff = i_touch_raw & i_input_enable & ~cal_busy_r;
  assign blk_en = multi_r[BLK_EN_BIT];
  assign lim = {1'b0, multi_r[LIMIT_LSB +: 2]} + 3'h1;

  // Held inputs stay; free slots go to inputs in order one to six
  always_comb begin
    logic [2:0] n;
    logic [5:0] held;
    n = 3'h0;
    held = acc_r & raw_eff;
    acc_nxt = raw_eff;
    if (blk_en) begin
      acc_nxt = 6'h00;
      // Held inputs first, trimmed in input order if the limit was lowered
      for (int i = 0; i < NUM_IN; i++) begin
        if (held[i] && n < lim) begin
          acc_nxt[i] = 1'b1;
          n = n + 3'h1;
        end
      end
      for (int i = 0; i < NUM_IN; i++) begin
        if (raw_eff[i] && !held[i] && n < lim) begin
          acc_nxt[i] = 1'b1;
          n = n + 3'h1;
        end
      end
    end
    simultaneous_touch_flag_nxt = blk_en && (ones(raw_eff) > lim);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_r <= 6'h00;
      simultaneous_touch_flag_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      simultaneous_touch_flag_r <= simultaneous_touch_flag_nxt;
    end
  end

  assign o_touch_status = acc_r;
  assign o_simultaneous_touch_flag = simultaneous_touch_flag_r;

  // ----------------------------------------
  // Events and interrupt request
  // ----------------------------------------
  for (genvar g = 0; g < NUM_IN; g++) begin : g_key
    tsc_key_event u_ev (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_tick(tick),
      .i_touch(acc_r[g]),
      .i_rpt_en(rpt_en_r[g]),
      .i_rel_sup(i_release_irq_suppress),
      .i_rpt_sel(i_repeat_interval_select),
      .o_event(key_ev[g])
    );
  end

  // Disabled inputs never reach the interrupt
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(key_ev & int_en_r);
    end
  end

  assign o_irq_req = irq_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_cal_req_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $fell(cal_req_r[0]) |-> $past(cal_busy_r[0]) && $past(cal_end[0]))
    else $error("request bit cleared without a finished routine");
  a_cal_no_press: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    cal_busy_r[0] && $past(cal_busy_r[0]) |-> !acc_r[0])
    else $error("press reported during recalibration");
  a_cal_restart: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    cal_busy_r[1] && i_touch_raw[1] |=> cal_busy_r[1] && o_cal_start[1]
      && (cal_tmr_r[1] == 5'h00))
    else $error("press did not restart recalibration");
  a_cal_value: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    cal_busy_r[2] && i_cal_done[2] && !i_touch_raw[2] |=> cal_val_r[2] == $past(i_cal_value)
      && !cal_busy_r[2])
    else $error("calibration value not updated at completion");
  a_irq_masked: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    int_en_r == 6'h00 && $past(int_en_r) == 6'h00 |-> !o_irq_req)
    else $error("interrupt raised from a disabled input");
  a_limit_kept: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    blk_en && $past(blk_en) && lim == $past(lim) |-> ones(acc_r) <= lim)
    else $error("more touches accepted than the limit");
  a_multi_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    blk_en && ones(raw_eff) > lim |=> simultaneous_touch_flag_r && (ones(acc_r) <= $past(lim)))
    else $error("excess touches not flagged");
  a_no_block: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    !blk_en ##1 !blk_en |-> acc_r == $past(raw_eff) && !simultaneous_touch_flag_r)
    else $error("touches blocked with blocking disabled");
endmodule
`default_nettype wire

// ---- tsc_pkg.sv ----
// Shared constants and types for the touch scan controller
package tsc_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int NUM_IN = 6;
  localparam int MEAS_W = 16;
  localparam int CAL_W = 10;
  localparam logic [2:0] CHAN_NONE = 3'h7;

  // ----------------------------------------
  // Register offsets and reset values
  // ----------------------------------------
  localparam logic [7:0] ADDR_SAMPLING = 8'h24;
  localparam logic [7:0] ADDR_CAL_REQ = 8'h26;
  localparam logic [7:0] ADDR_INT_EN = 8'h27;
  localparam logic [7:0] ADDR_RPT_EN = 8'h28;
  localparam logic [7:0] ADDR_MULTI = 8'h2a;
  localparam logic [7:0] RST_SAMPLING = 8'h39;
  localparam logic [7:0] RST_CAL_REQ = 8'h00;
  localparam logic [7:0] RST_INT_EN = 8'h3f;
  localparam logic [7:0] RST_RPT_EN = 8'h3f;
  localparam logic [7:0] RST_MULTI = 8'h80;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam logic [7:0] SAMPLING_MASK = 8'h7f;
  localparam logic [7:0] IN_MASK = 8'h3f;
  localparam logic [7:0] MULTI_MASK = 8'h8c;
  localparam int AVG_LSB = 4;
  localparam int SAMP_LSB = 2;
  localparam int CYCLE_LSB = 0;
  localparam int BLK_EN_BIT = 7;
  localparam int LIMIT_LSB = 2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int SAMPLE_BASE_US = 320;
  localparam int SAMPLE_BASE_CYC = SAMPLE_BASE_US * CLK_MHZ;
  localparam int TICK_MS = 35;
  localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
  localparam int CAL_MAX_MS = 600;
  localparam int CAL_TICKS = CAL_MAX_MS / TICK_MS;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] sample_count_select;
    logic [1:0] single_sample_duration;
    logic [1:0] cycle_period_select;
  } tsc_cfg_t;

  typedef struct packed {
    logic active;
    logic [2:0] chan;
  } tsc_afe_req_t;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [MEAS_W-1:0] value;
  } tsc_meas_t;
endpackage

// ---- tsc_scan_seq.sv ----
// Sampling sequencer: samples, averaging and cycle period
`timescale 1ns/1ps
`default_nettype none
module tsc_scan_seq #(
  parameter int SAMPLE_CYC = tsc_pkg::SAMPLE_BASE_CYC // Cycles of shortest sample
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_tick, // 35 ms enable pulse
  input wire logic i_active, // Active state
  input wire logic [5:0] i_input_enable, // Inputs in the scan
  input wire tsc_pkg::tsc_cfg_t i_cfg, // Sampling settings
  input wire logic [15:0] i_afe_count, // Front end sample result
  output var tsc_pkg::tsc_afe_req_t o_afe, // Front end request
  output var tsc_pkg::tsc_meas_t o_meas, // Averaged result
  output logic o_low_power // Idle rest of period
);
  import tsc_pkg::*;

  typedef enum {SQ_IDLE, SQ_SAMPLE, SQ_WAIT} tsc_seq_t;

  tsc_seq_t st_r;
  logic [2:0] chan_r;
  logic [6:0] smp_r;
  logic [15:0] dur_r;
  logic [22:0] acc_r;
  logic [2:0] per_r;
  logic [22:0] sum;
  logic last_smp;
  logic dur_end;
  logic per_end;

  // First enabled input at or above a start index
  function automatic logic [2:0] next_chan(input logic [5:0] en, input logic [3:0] from);
    logic [2:0] r;
    r = CHAN_NONE;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (en[i] && (4'(i) >= from)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Step conditions
  // ----------------------------------------
  assign sum = acc_r + {7'h00, i_afe_count};
  assign dur_end = (dur_r == ((16'(SAMPLE_CYC) << i_cfg.single_sample_duration) - 16'h0001));
  assign last_smp = (smp_r == 7'((8'h01 << i_cfg.sample_count_select) - 8'h01));
  // Period counter is in ticks; a stretched cycle leaves it past the end
  assign per_end = (per_r > {1'b0, i_cfg.cycle_period_select});

  // Sequencer: every sample of one input, then the next
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= SQ_IDLE;
      chan_r <= 3'h0;
      smp_r <= 7'h00;
      dur_r <= 16'h0000;
      acc_r <= 23'h000000;
    end else if (!i_active) begin
      st_r <= SQ_IDLE;
    end else begin
      case (st_r)
        SQ_IDLE, SQ_WAIT: begin
          if (st_r == SQ_IDLE || per_end) begin
            chan_r <= next_chan(i_input_enable, 4'h0);
            st_r <= (next_chan(i_input_enable, 4'h0) == CHAN_NONE) ? SQ_WAIT : SQ_SAMPLE;
            smp_r <= 7'h00;
            dur_r <= 16'h0000;
            acc_r <= 23'h000000;
          end
        end
        SQ_SAMPLE: begin
          if (!dur_end) begin
            dur_r <= dur_r + 16'h0001;
          end else begin
            dur_r <= 16'h0000;
            if (!last_smp) begin
              smp_r <= smp_r + 7'h01;
              acc_r <= sum;
            end else begin
              smp_r <= 7'h00;
              acc_r <= 23'h000000;
              chan_r <= next_chan(i_input_enable, {1'b0, chan_r} + 4'h1);
              if (next_chan(i_input_enable, {1'b0, chan_r} + 4'h1) == CHAN_NONE) begin
                st_r <= SQ_WAIT;
              end
            end
          end
        end
        default: st_r <= SQ_IDLE;
      endcase
    end
  end

  // Period timer restarts as a new cycle starts, saturates otherwise
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      per_r <= 3'h0;
    end else if ((st_r == SQ_IDLE || (st_r == SQ_WAIT && per_end)) && i_active) begin
      per_r <= 3'h0;
    end else if (i_tick && per_r != 3'h7) begin
      per_r <= per_r + 3'h1;
    end
  end

  // Averaged result leaves the block once per input
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_meas <= '0;
    end else begin
      o_meas.valid <= (st_r == SQ_SAMPLE) && dur_end && last_smp && i_active;
      o_meas.chan <= chan_r;
      o_meas.value <= MEAS_W'(sum >> i_cfg.sample_count_select);
    end
  end

  assign o_afe.active = (st_r == SQ_SAMPLE);
  assign o_afe.chan = chan_r;
  assign o_low_power = (st_r == SQ_WAIT);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_period_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (st_r == SQ_WAIT) && i_active && !per_end |=> (st_r != SQ_SAMPLE))
    else $error("new scan started before the period ended");
  a_result_after_all: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_meas.valid |-> $past(last_smp) && $past(st_r == SQ_SAMPLE))
    else $error("result published before all samples were taken");
endmodule
`default_nettype wire

// ---- tsc_key_event.sv ----
// Touch, release and auto-repeat event generator for one input
`timescale 1ns/1ps
`default_nettype none
module tsc_key_event (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_tick, // 35 ms enable pulse
  input wire logic i_touch, // Accepted touch level
  input wire logic i_rpt_en, // Auto-repeat enable
  input wire logic i_rel_sup, // Release event suppressed if repeat enabled
  input wire logic [3:0] i_rpt_sel, // Repeat interval code
  output logic o_event // One-cycle event pulse
);
  import tsc_pkg::*;

  logic touch_d_r;
  logic [3:0] rpt_r;
  logic rise;
  logic fall;
  logic rpt_hit;

  assign rise = i_touch && !touch_d_r;
  assign fall = !i_touch && touch_d_r;
  // Interval is (code + 1) ticks of 35 ms
  assign rpt_hit = i_touch && touch_d_r && i_rpt_en && i_tick && (rpt_r == i_rpt_sel);

  // Edge history and repeat counter
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      touch_d_r <= 1'b0;
      rpt_r <= 4'h0;
    end else begin
      touch_d_r <= i_touch;
      if (rise || rpt_hit) begin
        rpt_r <= 4'h0;
      end else if (i_touch && i_tick) begin
        rpt_r <= rpt_r + 4'h1;
      end
    end
  end

  // Press always, release unless repeat and suppress, repeat while held
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_event <= 1'b0;
    end else begin
      o_event <= rise || rpt_hit || (fall && !(i_rpt_en && i_rel_sup));
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_press_event: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $rose(touch_d_r) |-> o_event)
    else $error("touch did not raise an event");
  a_release_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $fell(touch_d_r) && $past(i_rpt_en) && $past(i_rel_sup) |-> !o_event)
    else $error("suppressed release still raised an event");
endmodule
`default_nettype wire

// ---- tsc_afe_model.sv ----
// Front end model: sample counts and calibration completion
`timescale 1ns/1ps
`default_nettype none
module tsc_afe_model #(
  parameter int CAL_DLY = 10 // Cycles from start to done
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_b, // Async reset, active low
  input wire tsc_pkg::tsc_afe_req_t i_req, // Sample request
  input wire logic [5:0] i_cal_start, // Calibration start pulses
  output logic [15:0] o_count, // Sample result
  output logic [5:0] o_cal_done, // Calibration done pulses
  output logic [9:0] o_cal_value // Calibration result
);
  import tsc_pkg::*;
  logic [5:0] busy_r;
  int cnt_r;
  // Count per input; outside a sample it churns so stale data never matches
  always_comb o_count = i_req.active ? 16'h0100 + 16'(i_req.chan) : 16'(cnt_r) ^ 16'hffff;
  always_comb o_cal_value = (o_cal_done != 6'h00) ? 10'h2a5 : 10'(cnt_r);
  // Calibration runs a fixed time; a restart pushes the finish out
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_r <= 6'h00;
      cnt_r <= 0;
      o_cal_done <= 6'h00;
    end else begin
      cnt_r <= (i_cal_start != 6'h00) ? 0 : cnt_r + 1;
      busy_r <= (cnt_r == CAL_DLY) ? i_cal_start : (busy_r | i_cal_start);
      o_cal_done <= (cnt_r == CAL_DLY) ? busy_r & ~i_cal_start : 6'h00;
    end
  end
endmodule
`default_nettype wire

// ---- touch_scan_calib_and_blocking_test.sv ----
// Self-checking bench for the touch scan controller
`timescale 1ns/1ps
`default_nettype none
module touch_scan_calib_and_blocking_test;
  import tsc_pkg::*;
  logic clk, rst_b, wr, rd, act, sup, lp, flag, irq;
  logic [7:0] addr, wdata, rdata, d;
  logic [5:0] en, raw, cdone, cstart, bval, tst;
  logic [3:0] rsel;
  logic [15:0] cnt;
  logic [9:0] cval;
  logic [59:0] calv;
  tsc_afe_req_t req;
  tsc_meas_t meas;
  int n_errors = 0;
  int compares = 0;
  int k;
  logic [7:0] ra[6] = '{8'h24, 8'h26, 8'h27, 8'h28, 8'h2a, 8'h25};
  logic [7:0] re[6] = '{8'h39, 8'h00, 8'h3f, 8'h3f, 8'h80, 8'h00};
  tsc_touch_ctrl #(.TICK_CYC_P(20), .SAMPLE_CYC_P(4)) u_dut (.i_sys_clk(clk), .i_rst_b(rst_b),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_active(act), .i_input_enable(en), .i_release_irq_suppress(sup),
    .i_repeat_interval_select(rsel), .i_afe_count(cnt), .o_afe_req(req), .o_meas(meas),
    .o_low_power(lp), .i_touch_raw(raw), .i_cal_done(cdone), .i_cal_value(cval),
    .o_cal_start(cstart), .o_calibration_value(calv), .o_base_valid(bval),
    .o_touch_status(tst), .o_simultaneous_touch_flag(flag), .o_irq_req(irq));
  tsc_afe_model u_afe (.i_sys_clk(clk), .i_rst_b(rst_b), .i_req(req), .i_cal_start(cstart),
    .o_count(cnt), .o_cal_done(cdone), .o_cal_value(cval));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Strobes are one cycle wide; read data is taken after the read edge
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // Bounded wait: 0 for a result, 1 for input 1 calibration end
  task automatic wait_for(input int sel);
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk);
      if ((sel == 0 ? meas.valid : bval[0]) === 1'b1) return;
    end
    n_errors++;
    final_report();
  endtask
  task automatic cnt_irq(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      if (irq === 1'b1) c++;
    end
  endtask
  initial begin
    {rst_b, wr, rd, act, sup, addr, wdata, raw, rsel} = '0;
    en = 6'h05;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, then an unmapped offset
    foreach (ra[i]) begin
      rreg(ra[i], d);
      chk(16'(d), 16'(re[i]));
    end
    // Four samples per input, inputs 1 and 3 only, in order
    wreg(8'h24, 8'h20);
    rreg(8'h24, d);
    chk(16'(d), 16'h0020);
    act <= 1'b1;
    wait_for(0);
    chk({13'h0, meas.chan}, 16'h0000);
    chk(meas.value, 16'h0100);
    wait_for(0);
    chk({13'h0, meas.chan}, 16'h0002);
    chk(meas.value, 16'h0102);
    chk(16'(lp), 16'h0001);
    // Forced recalibration of input 1
    en <= 6'h3f;
    wreg(8'h26, 8'h01);
    repeat (3) @(negedge clk);
    chk(16'(bval), 16'h003e);
    wait_for(1);
    @(negedge clk);
    chk(16'(calv[9:0]), 16'h02a5);
    rreg(8'h26, d);
    chk(16'(d), 16'h0000);
    // Two touches against a limit of one, then limit two, then no blocking
    raw <= 6'h03;
    repeat (4) @(negedge clk);
    chk({flag, 9'h0, tst}, 16'h8001);
    raw <= 6'h07;
    wreg(8'h2a, 8'h84);
    repeat (4) @(negedge clk);
    chk({flag, 9'h0, tst}, 16'h8003);
    wreg(8'h2a, 8'h00);
    repeat (4) @(negedge clk);
    chk({flag, 9'h0, tst}, 16'h0007);
    // Masked touch is silent; enabled release still interrupts
    raw <= 6'h00;
    wreg(8'h2a, 8'h80);
    wreg(8'h27, 8'h00);
    wreg(8'h28, 8'h00);
    raw <= 6'h01;
    cnt_irq(10, k);
    chk(16'(k), 16'h0000);
    wreg(8'h27, 8'h3f);
    raw <= 6'h00;
    cnt_irq(10, k);
    chk(16'(k), 16'h0001);
    // Held touch repeats every step; a suppressed release stays quiet
    wreg(8'h28, 8'h01);
    raw <= 6'h01;
    cnt_irq(63, k);
    chk(16'(k), 16'h0004);
    rsel <= 4'hf;
    sup <= 1'b1;
    raw <= 6'h00;
    cnt_irq(10, k);
    chk(16'(k), 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
